/* common/exec_regs.svh */
// Opcode fields, flag positions, address limits and register offsets of the execution block.
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

`define OPC_AND_LIT     8'h0b
`define OPC_AND_FILE    6'h05
`define OPC_ADD_CARRY   6'h08
`define OPC_CLR_BIT     4'h9
`define OPC_BRANCH_HI   4'he
`define BRC_CARRY_SET   4'h2
`define BRC_CARRY_CLR   4'h3
`define BRC_NEG_SET     4'h6

`define FLAG_C          0
`define FLAG_DIG        1
`define FLAG_Z          2
`define FLAG_OVF        3
`define FLAG_N          4
`define FLAGS_W         5

`define IDX_LIMIT       8'h5f
`define ACC_SPLIT       8'h60
`define ACC_LO_BANK     4'h0
`define ACC_HI_BANK     4'hf
`define PC_STEP         2
`define BIT_ONE         8'h01

`define REG_CTRL        12'h000
`define REG_BANK        12'h004
`define REG_ACC         12'h008
`define REG_FLAGS       12'h00c
`define REG_PC          12'h010
`define CTRL_EXT_BIT    0
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define RST_ACC         8'h00
`define RST_BANK        4'h0
`define RST_FLAGS       5'h00

`endif

/* common/exec_pkg.sv */
// Types shared by the execution block files.
`default_nettype none
package exec_pkg;
  typedef enum logic [1:0] {PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b11, PH_Q4 = 2'b10} phase_t;
  typedef enum logic [2:0] {OP_NONE, OP_AND_LIT, OP_AND_FILE, OP_ADD_CARRY, OP_CLR_BIT, OP_BRANCH} op_t;
endpackage
`default_nettype wire

/* rtl/branch_unit.sv */
// Condition test and target arithmetic for the conditional relative branches.
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.svh"
module branch_unit #(
  parameter int PC_W = 21
) (
  input  wire logic [3:0]      condSel,
  input  wire logic            carry,
  input  wire logic            negative,
  input  wire logic [PC_W-1:0] pcNow,
  input  wire logic [7:0]      offset,
  output logic                 taken,
  output logic [PC_W-1:0]      target
);
  always_comb
  begin
    case (condSel)
      `BRC_CARRY_SET: taken = carry;
      `BRC_NEG_SET:   taken = negative;
      `BRC_CARRY_CLR: taken = !carry;
      default:        taken = 1'b0;
    endcase
  end

  // The offset counts instruction words, so it is doubled before the add.
  assign target = pcNow + PC_W'(`PC_STEP) + {{(PC_W-9){offset[7]}}, offset, 1'b0};
endmodule
`default_nettype wire

/* rtl/and_branch_bitclear_exec.sv */
// Execution block for the AND, bit-clear, add-with-carry and conditional branch instructions.
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.svh"
module and_branch_bitclear_exec #(
  parameter int PC_W = 21
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  input  wire logic [11:0] idxBase,
  input  wire logic [7:0]  memRdData,
  output logic [11:0]      memAddr,
  output logic             memRdEn,
  output logic             memWrEn,
  output logic [7:0]       memWrData,
  output logic [PC_W-1:0]  pc,
  output logic             branchTaken,
  output exec_pkg::phase_t phase,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic                  extEnable;
  logic [3:0]            bank;
  logic [7:0]            acc;
  logic [`FLAGS_W-1:0]   flags;
  exec_pkg::op_t         curOp;
  exec_pkg::op_t         next_op;
  logic                  executing;
  logic                  nopCycle;
  logic                  dBit;
  logic [7:0]            litByte;
  logic [2:0]            bitSel;
  logic [3:0]            condSel;
  logic                  commit;
  logic                  accWr;
  logic                  fileWr;
  logic                  flagsWr;
  logic [7:0]            result;
  logic [`FLAGS_W-1:0]   next_flags;
  logic [8:0]            sum9;
  logic [4:0]            sumLo;
  logic                  condTaken;
  logic [PC_W-1:0]       brTarget;
  logic                  awHeld;
  logic                  wHeld;
  logic [11:0]           awAddrQ;
  logic [7:0]            wByteQ;
  logic                  wLane0;
  logic                  doWrite;
  logic                  swWr;

  function automatic exec_pkg::op_t decodeOp(input logic [15:0] w);
    if (w[15:8] == `OPC_AND_LIT)
      decodeOp = exec_pkg::OP_AND_LIT;
    else if (w[15:10] == `OPC_AND_FILE)
      decodeOp = exec_pkg::OP_AND_FILE;
    else if (w[15:10] == `OPC_ADD_CARRY)
      decodeOp = exec_pkg::OP_ADD_CARRY;
    else if (w[15:12] == `OPC_CLR_BIT)
      decodeOp = exec_pkg::OP_CLR_BIT;
    else if (w[15:12] == `OPC_BRANCH_HI && (w[11:8] == `BRC_CARRY_SET ||
             w[11:8] == `BRC_CARRY_CLR || w[11:8] == `BRC_NEG_SET))
      decodeOp = exec_pkg::OP_BRANCH;
    else
      decodeOp = exec_pkg::OP_NONE;
  endfunction

  function automatic logic [11:0] effAddr(input logic [7:0] f, input logic a, input logic ext,
                                          input logic [3:0] bk, input logic [11:0] idx);
    if (a)
      effAddr = {bk, f};
    else if (ext && f <= `IDX_LIMIT)
      effAddr = idx + {4'h0, f};
    else if (f < `ACC_SPLIT)
      effAddr = {`ACC_LO_BANK, f};
    else
      effAddr = {`ACC_HI_BANK, f};
  endfunction

  function automatic logic readsFile(input exec_pkg::op_t op);
    readsFile = (op == exec_pkg::OP_AND_FILE) || (op == exec_pkg::OP_ADD_CARRY) ||
                (op == exec_pkg::OP_CLR_BIT);
  endfunction

  // The instruction cycle runs Q1 to Q4 on four consecutive clocks.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      phase <= exec_pkg::PH_Q1;
    else
      case (phase)
        exec_pkg::PH_Q1: phase <= exec_pkg::PH_Q2;
        exec_pkg::PH_Q2: phase <= exec_pkg::PH_Q3;
        exec_pkg::PH_Q3: phase <= exec_pkg::PH_Q4;
        exec_pkg::PH_Q4: phase <= exec_pkg::PH_Q1;
        default:         phase <= exec_pkg::PH_Q1;
      endcase
  end

  assign next_op = (instrValid && !nopCycle) ? decodeOp(instrWord) : exec_pkg::OP_NONE;
  assign commit  = (phase == exec_pkg::PH_Q3) && executing;

  // Decode is latched at the end of Q1; the word must be steady during Q1.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      curOp     <= exec_pkg::OP_NONE;
      executing <= 1'b0;
      dBit      <= 1'b0;
      litByte   <= 8'h00;
      bitSel    <= 3'h0;
      condSel   <= 4'h0;
    end
    else if (phase == exec_pkg::PH_Q1)
    begin
      curOp     <= next_op;
      executing <= instrValid && !nopCycle;
      dBit      <= instrWord[9];
      litByte   <= instrWord[7:0];
      bitSel    <= instrWord[11:9];
      condSel   <= instrWord[11:8];
    end
  end

  // Operand read is issued during Q2 and its data is used during Q3.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memRdEn <= 1'b0;
      memAddr <= 12'h000;
    end
    else if (phase == exec_pkg::PH_Q1 && readsFile(next_op))
    begin
      memRdEn <= 1'b1;
      memAddr <= effAddr(instrWord[7:0], instrWord[8], extEnable, bank, idxBase);
    end
    else
      memRdEn <= 1'b0;
  end

  branch_unit #(
    .PC_W (PC_W)
  ) u_branch (
    .condSel  (condSel),
    .carry    (flags[`FLAG_C]),
    .negative (flags[`FLAG_N]),
    .pcNow    (pc),
    .offset   (litByte),
    .taken    (condTaken),
    .target   (brTarget)
  );

  always_comb
  begin
    accWr      = 1'b0;
    fileWr     = 1'b0;
    flagsWr    = 1'b0;
    result     = 8'h00;
    next_flags = flags;
    sum9       = {1'b0, acc} + {1'b0, memRdData} + {8'h00, flags[`FLAG_C]};
    sumLo      = {1'b0, acc[3:0]} + {1'b0, memRdData[3:0]} + {4'h0, flags[`FLAG_C]};
    case (curOp)
      exec_pkg::OP_AND_LIT:
      begin
        result  = acc & litByte;
        accWr   = 1'b1;
        flagsWr = 1'b1;
      end
      exec_pkg::OP_AND_FILE:
      begin
        result  = acc & memRdData;
        accWr   = !dBit;
        fileWr  = dBit;
        flagsWr = 1'b1;
      end
      exec_pkg::OP_ADD_CARRY:
      begin
        result  = sum9[7:0];
        accWr   = !dBit;
        fileWr  = dBit;
        flagsWr = 1'b1;
        next_flags[`FLAG_C]  = sum9[8];
        next_flags[`FLAG_DIG] = sumLo[4];
        next_flags[`FLAG_OVF] = (acc[7] == memRdData[7]) && (sum9[7] != acc[7]);
      end
      exec_pkg::OP_CLR_BIT:
      begin
        result = memRdData & ~(`BIT_ONE << bitSel);
        fileWr = 1'b1;
      end
      default: result = 8'h00;
    endcase
    // Only N and Z follow the result for the AND forms; other bits keep their value.
    next_flags[`FLAG_N] = result[7];
    next_flags[`FLAG_Z] = (result == 8'h00);
  end

  // Results land on the Q3-to-Q4 edge so they are visible throughout Q4.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      acc <= `RST_ACC;
    else if (commit && accWr)
      acc <= result;
    else if (swWr && awAddrQ == `REG_ACC)
      acc <= wByteQ;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags <= `RST_FLAGS;
    else if (commit && flagsWr)
      flags <= next_flags;
    else if (swWr && awAddrQ == `REG_FLAGS)
      flags <= wByteQ[`FLAGS_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memWrEn   <= 1'b0;
      memWrData <= 8'h00;
    end
    else
    begin
      memWrEn <= commit && fileWr;
      if (commit && fileWr)
        memWrData <= result;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc          <= '0;
      branchTaken <= 1'b0;
      nopCycle    <= 1'b0;
    end
    else
    begin
      branchTaken <= commit && curOp == exec_pkg::OP_BRANCH && condTaken;
      if (commit && curOp == exec_pkg::OP_BRANCH && condTaken)
      begin
        pc       <= brTarget;
        nopCycle <= 1'b1;
      end
      else if (commit)
        pc <= pc + PC_W'(`PC_STEP);
      else if (phase == exec_pkg::PH_Q1)
        nopCycle <= 1'b0;
    end
  end

  // Software writes wait out the Q3 cycle so they never collide with a result.
  assign doWrite = awHeld && wHeld && !s_axi_bvalid && phase != exec_pkg::PH_Q3;
  assign swWr    = doWrite && wLane0;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddrQ       <= 12'h000;
      wByteQ        <= 8'h00;
      wLane0        <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        awHeld        <= 1'b1;
        awAddrQ       <= s_axi_awaddr;
      end
      else if (!awHeld && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wHeld        <= 1'b1;
        wByteQ       <= s_axi_wdata[7:0];
        wLane0       <= s_axi_wstrb[0];
      end
      else if (!wHeld && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (doWrite)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddrQ == `REG_CTRL || awAddrQ == `REG_BANK || awAddrQ == `REG_ACC ||
                         awAddrQ == `REG_FLAGS || awAddrQ == `REG_PC) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      extEnable <= 1'b0;
      bank      <= `RST_BANK;
    end
    else if (swWr && awAddrQ == `REG_CTRL)
      extEnable <= wByteQ[`CTRL_EXT_BIT];
    else if (swWr && awAddrQ == `REG_BANK)
      bank <= wByteQ[3:0];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL:  s_axi_rdata <= 32'(extEnable);
        `REG_BANK:  s_axi_rdata <= 32'(bank);
        `REG_ACC:   s_axi_rdata <= 32'(acc);
        `REG_FLAGS: s_axi_rdata <= 32'(flags);
        `REG_PC:    s_axi_rdata <= 32'(pc);
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_AND_LIT_ACC: assert property ((commit && curOp == exec_pkg::OP_AND_LIT) |=>
    acc == ($past(acc) & $past(litByte))) else $error("literal AND result wrong");
  AST_AND_FLAGS_NZ: assert property ((commit && (curOp == exec_pkg::OP_AND_LIT ||
    curOp == exec_pkg::OP_AND_FILE)) |=> flags[`FLAG_C] == $past(flags[`FLAG_C]) &&
    flags[`FLAG_OVF] == $past(flags[`FLAG_OVF]) && flags[`FLAG_DIG] == $past(flags[`FLAG_DIG]) &&
    flags[`FLAG_Z] == (acc == 8'h00 && !$past(dBit) || $past(result) == 8'h00))
    else $error("AND touched a flag other than N and Z");
  AST_AND_FILE_DEST: assert property ((commit && curOp == exec_pkg::OP_AND_FILE && dBit) |=>
    memWrEn && memWrData == ($past(acc) & $past(memRdData)) && acc == $past(acc))
    else $error("file AND did not write the file");
  AST_BANKED_ADDR: assert property ((phase == exec_pkg::PH_Q1 && readsFile(next_op) && instrWord[8])
    |=> memRdEn && memAddr == {$past(bank), $past(instrWord[7:0])}) else $error("banked address wrong");
  AST_INDEXED_ADDR: assert property ((phase == exec_pkg::PH_Q1 && readsFile(next_op) && !instrWord[8] &&
    extEnable && instrWord[7:0] <= `IDX_LIMIT) |=> memAddr == $past(idxBase) + {4'h0, $past(instrWord[7:0])})
    else $error("indexed address wrong");
  AST_BRANCH_COND: assert property ((commit && curOp == exec_pkg::OP_BRANCH) |=>
    branchTaken == ($past(condSel) == `BRC_CARRY_SET ? $past(flags[`FLAG_C]) :
    $past(condSel) == `BRC_CARRY_CLR ? !$past(flags[`FLAG_C]) : $past(flags[`FLAG_N])))
    else $error("branch condition misjudged");
  AST_BRANCH_TARGET: assert property (branchTaken |-> pc == $past(pc) + PC_W'(`PC_STEP) +
    PC_W'({{(PC_W-9){$past(litByte[7])}}, $past(litByte), 1'b0})) else $error("branch target wrong");
  AST_TAKEN_IDLE: assert property (branchTaken |-> phase == exec_pkg::PH_Q4 ##1
    (!memRdEn && !memWrEn && !branchTaken) [*5]) else $error("idle cycle after branch not idle");
  AST_CLR_BIT: assert property ((commit && curOp == exec_pkg::OP_CLR_BIT) |=> memWrEn &&
    memWrData == ($past(memRdData) & ~(`BIT_ONE << $past(bitSel))) && flags == $past(flags))
    else $error("bit clear wrong");
  AST_ADD_CARRY: assert property ((commit && curOp == exec_pkg::OP_ADD_CARRY && !dBit) |=>
    acc == ($past(acc) + $past(memRdData) + 8'($past(flags[`FLAG_C])))) else $error("add with carry wrong");
  AST_PHASE_ORDER: assert property (phase == exec_pkg::PH_Q1 |=> phase == exec_pkg::PH_Q2 ##1
    phase == exec_pkg::PH_Q3 ##1 phase == exec_pkg::PH_Q4 ##1 phase == exec_pkg::PH_Q1)
    else $error("phase order broken");
  AST_BRANCH_FLAGS: assert property ((commit && curOp == exec_pkg::OP_BRANCH) |=>
    flags == $past(flags)) else $error("branch changed a flag");

  COV_TAKEN: cover property (branchTaken);
  COV_NOT_TAKEN: cover property (commit && curOp == exec_pkg::OP_BRANCH && !condTaken);
  COV_FILE_AND: cover property (commit && curOp == exec_pkg::OP_AND_FILE && dBit);
  COV_CLR_BIT: cover property (commit && curOp == exec_pkg::OP_CLR_BIT);
endmodule
`default_nettype wire

/* verification/data_mem_model.sv */
// Behavioural banked data memory that answers the execution block's reads and takes its writes.
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [11:0] memAddr,
  input  wire logic        memRdEn,
  input  wire logic        memWrEn,
  input  wire logic [7:0]  memWrData,
  output logic [7:0]       memRdData
);
  logic [7:0] mem [0:4095];

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    memRdData = 8'h00;
  end

  // Outside its read cycle the bus toggles, so data sampled in the wrong phase shows as a wrong value.
  always @(posedge ref_clk)
  begin
    if (memRdEn)
      memRdData <= mem[memAddr];
    else
      memRdData <= ~memRdData;
    if (memWrEn)
      mem[memAddr] <= memWrData;
  end
endmodule
`default_nettype wire

/* verification/test_and_branch_bitclear_exec.sv */
// Self-checking bench for the execution block: instructions, data memory and register bus.
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs.svh"
module test_and_branch_bitclear_exec;
  localparam int PC_W = 21;
  logic             ref_clk;
  logic             rst_b;
  logic [15:0]      instrWord;
  logic             instrValid;
  logic [11:0]      idxBase;
  logic [7:0]       memRdData;
  logic [11:0]      memAddr;
  logic             memRdEn;
  logic             memWrEn;
  logic [7:0]       memWrData;
  logic [PC_W-1:0]  pc;
  logic             branchTaken;
  exec_pkg::phase_t phase;
  logic [11:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int               fails, checksDone, cyc;
  logic [31:0]      rd;
  logic [1:0]       rsp;
  logic             sawRd, sawWr, sawBr;
  logic [PC_W-1:0]  pcExp;
  logic [7:0]       r;
  logic [4:0]       fe;

  and_branch_bitclear_exec #(.PC_W(PC_W)) u_and_branch_bitclear_exec (
    .ref_clk, .rst_b, .instrWord, .instrValid, .idxBase, .memRdData, .memAddr, .memRdEn, .memWrEn,
    .memWrData, .pc, .branchTaken, .phase, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  data_mem_model u_data_mem_model (.ref_clk, .memAddr, .memRdEn, .memWrEn, .memWrData, .memRdData);

  initial
  begin
    ref_clk = 1'b0;
    forever
      #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic axW(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic axR(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // With now set the word goes into the very next cycle, which after a taken branch is the idle one.
  task automatic doI(input logic [15:0] w, input bit now = 1'b0);
    if (!now)
    begin
      do
        @(posedge ref_clk);
      while (phase !== exec_pkg::PH_Q4);
    end
    instrWord <= w;
    instrValid <= 1'b1;
    @(posedge ref_clk);
    instrValid <= 1'b0;
    @(posedge ref_clk);
    sawRd = memRdEn;
    repeat (2) @(posedge ref_clk);
    sawWr = memWrEn;
    sawBr = branchTaken;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  logic [7:0]  lA [3] = '{8'hf3, 8'hff, 8'h5a};
  logic [7:0]  lK [3] = '{8'h0c, 8'h80, 8'hff};
  logic        fb [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0]  ff [5] = '{8'h20, 8'h70, 8'h5f, 8'h60, 8'h10};
  logic        fx [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [11:0] fa [5] = '{12'h020, 12'hf70, 12'h25f, 12'hf60, 12'h310};
  logic [3:0]  cnd [6] = '{4'h2, 4'h2, 4'h6, 4'h6, 4'h3, 4'h3};
  logic [4:0]  bf [6] = '{5'h01, 5'h1e, 5'h10, 5'h0f, 5'h1e, 5'h01};
  logic [7:0]  bo [6] = '{8'h80, 8'h05, 8'h7f, 8'h7f, 8'hfe, 8'h01};

  initial
  begin
    fails = 0;
    checksDone = 0;
    cyc = 0;
    rst_b = 1'b0;
    instrWord = 16'h0000;
    instrValid = 1'b0;
    idxBase = 12'h200;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    pcExp = '0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    axR(12'h020);
    check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    check(rd, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      axW(`REG_ACC, {24'h0, lA[i]});
      axW(`REG_FLAGS, 32'h0b);
      doI({`OPC_AND_LIT, lK[i]});
      pcExp += 2;
      r = lA[i] & lK[i];
      fe = 5'h0b;
      fe[`FLAG_Z] = (r == 8'h00);
      fe[`FLAG_N] = r[7];
      axR(`REG_ACC);
      check(rd, {24'h0, r});
      axR(`REG_FLAGS);
      check(rd, {27'h0, fe});
      check({11'h0, pc}, {11'h0, pcExp});
    end
    axW(`REG_BANK, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      axW(`REG_CTRL, {31'h0, fx[i]});
      axW(`REG_ACC, 32'h17);
      axW(`REG_FLAGS, 32'h15);
      u_data_mem_model.mem[fa[i]] = 8'hc2;
      doI({`OPC_AND_FILE, 1'b0, fb[i], ff[i]});
      u_data_mem_model.mem[fa[i]] = 8'h00;
      pcExp += 2;
      axR(`REG_ACC);
      check(rd, 32'h02);
      check({30'h0, sawRd, sawWr}, 32'h2);
      axR(`REG_FLAGS);
      check(rd, 32'h01);
    end
    axW(`REG_CTRL, 32'h0);
    axW(`REG_ACC, 32'h17);
    u_data_mem_model.mem[12'h345] = 8'hc2;
    doI({`OPC_AND_FILE, 1'b1, 1'b1, 8'h45});
    pcExp += 2;
    // The model stores on the edge that ends Q4, so look one edge later.
    @(posedge ref_clk);
    check({24'h0, u_data_mem_model.mem[12'h345]}, 32'h02);
    axR(`REG_ACC);
    check(rd, 32'h17);
    axW(`REG_FLAGS, 32'h1f);
    for (int b = 0; b < 8; b++)
    begin
      u_data_mem_model.mem[12'h381] = 8'hff;
      doI({`OPC_CLR_BIT, 3'(b), 1'b1, 8'h81});
      pcExp += 2;
      @(posedge ref_clk);
      check({24'h0, u_data_mem_model.mem[12'h381]}, {24'h0, ~(`BIT_ONE << b)});
    end
    axR(`REG_FLAGS);
    check(rd, 32'h1f);
    for (int i = 0; i < 2; i++)
    begin
      axW(`REG_ACC, i ? 32'h7f : 32'h4d);
      axW(`REG_FLAGS, 32'h01);
      u_data_mem_model.mem[12'h310] = i ? 8'h00 : 8'h02;
      doI({`OPC_ADD_CARRY, 1'(i), 1'b1, 8'h10});
      pcExp += 2;
      axR(`REG_ACC);
      check(rd, i ? 32'h7f : 32'h50);
      axR(`REG_FLAGS);
      check(rd, i ? 32'h1a : 32'h02);
      check({24'h0, u_data_mem_model.mem[12'h310]}, i ? 32'h80 : 32'h02);
    end
    for (int i = 0; i < 6; i++)
    begin
      axW(`REG_FLAGS, {27'h0, bf[i]});
      doI({`OPC_BRANCH_HI, cnd[i], bo[i]});
      pcExp = pcExp + 21'd2 + (i % 2 == 0 ? {{12{bo[i][7]}}, bo[i], 1'b0} : 21'd0);
      check({11'h0, pc}, {11'h0, pcExp});
      check({31'h0, sawBr}, {31'h0, i % 2 == 0});
      // The refused word must meet the Q1 of the idle cycle, so nothing may come between.
      if (i % 2 == 0)
      begin
        doI({`OPC_AND_LIT, 8'h00}, 1'b1);
        check({11'h0, pc}, {11'h0, pcExp});
      end
      axR(`REG_FLAGS);
      check(rd, {27'h0, bf[i]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
